/* hdl/udrt_cfg.svh */
`ifndef UDRT_CFG_SVH
`define UDRT_CFG_SVH

// ----------------------------------------
// Clock and time base
// ----------------------------------------
`define UDRT_CLK_KHZ 125000
`define UDRT_MSW 13

// ----------------------------------------
// Timing limits in milliseconds
// ----------------------------------------
`define UDRT_RECOV_MS 4'd10
`define UDRT_NODATA_MS 13'd50
`define UDRT_IN_PKT_MS 13'd500
`define UDRT_STATUS_MS 13'd50
`define UDRT_CMD_MS 13'd5000

// ----------------------------------------
// Capabilities and version
// ----------------------------------------
`define UDRT_HS_CAPABLE 1'b1
`define UDRT_WAKE_CAPABLE 1'b1
`define UDRT_BCD_VER 16'h0200
`define UDRT_OTHER_SPEED_VER 16'h0200
`define UDRT_NUM_EP 4

// ----------------------------------------
// Setup field positions and codes
// ----------------------------------------
`define UDRT_DIR_BIT 7
`define UDRT_TYPE_HI 6
`define UDRT_TYPE_LO 5
`define UDRT_RECIP_HI 4
`define UDRT_TYPE_STD 2'h0
`define UDRT_TYPE_CLASS 2'h1
`define UDRT_TYPE_RSVD 2'h3
`define UDRT_RECIP_DEV 5'h00
`define UDRT_REQ_CLR_FEAT 8'h01
`define UDRT_REQ_SET_FEAT 8'h03
`define UDRT_REQ_SET_ADDR 8'h05
`define UDRT_REQ_GET_DESC 8'h06
`define UDRT_DT_QUAL 8'h06
`define UDRT_DT_OTHER_CFG 8'h07
`define UDRT_FEAT_WAKEUP 16'h0001
`define UDRT_ADDRW 7

`endif

/* hdl/udrt_pkg.sv */
package udrt_pkg;

  typedef enum logic [3:0]
  {
    s_idle = 4'b0001,
    s_in = 4'b0010,
    s_out = 4'b0100,
    s_stat = 4'b1000
  } udrt_state_t;

  typedef enum logic [1:0]
  {
    ep_ctrl = 2'h0,
    ep_iso = 2'h1,
    ep_bulk = 2'h2,
    ep_intr = 2'h3
  } udrt_ep_type_t;

endpackage

/* hdl/udrt_tmr_if.sv */
`timescale 1ns/1ns
`include "udrt_cfg.svh"

interface udrt_tmr_if;
  logic restart;
  logic tick;
  logic [`UDRT_MSW-1:0] ms;

  modport tmr (input restart, output tick, output ms);
  modport usr (output restart, input tick, input ms);
endinterface

/* hdl/udrt_ms_timer.sv */
`timescale 1ns/1ns
`include "udrt_cfg.svh"

module udrt_ms_timer #(
  parameter int CYC_PER_MS = `UDRT_CLK_KHZ
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Time base
  udrt_tmr_if.tmr t
);

  localparam int CW = $clog2(CYC_PER_MS + 1);

  logic [CW-1:0] cyc_r;

  // ----------------------------------------
  // Free running millisecond tick
  // ----------------------------------------
  // Never restarted, so recovery timing stays on a steady grid
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      cyc_r <= '0;
      t.tick <= 1'b0;
    end
    else if (cyc_r == CW'(CYC_PER_MS - 1))
    begin
      cyc_r <= '0;
      t.tick <= 1'b1;
    end
    else
    begin
      cyc_r <= cyc_r + CW'(1);
      t.tick <= 1'b0;
    end
  end

  // ----------------------------------------
  // Elapsed milliseconds since restart
  // ----------------------------------------
  // Saturates so a stuck request stays flagged late
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      t.ms <= '0;
    else if (t.restart)
      t.ms <= '0;
    else if (t.tick && t.ms != {`UDRT_MSW{1'b1}})
      t.ms <= t.ms + `UDRT_MSW'(1);
  end

endmodule

/* hdl/udrt_top.sv */
// Function
// - Each endpoint keeps one transfer type until another alternate setting is chosen.
// - Host can enable and disable remote wakeup through standard feature requests.
// - Processing may start once setup is acknowledged, except for set-address.
// - Processing finishes before the status stage may complete.
// - Long operations report completion through a separate flag, not the status stage.
// - No command may take longer than five seconds.
// - Host waits 10 ms after reset or resume; transfers meanwhile may be ignored.
// - After recovery the device accepts transfers at any time; xfer_ok rises only 10 to 11 ms after reset or resume ends.
// - Set-address completes with status within 50 ms of receipt.
// - Set-address status completes on zero-length packet sent or host handshake seen.
// - Within 2 ms of that status, switch to the new address.
// - Standard requests without data stage finish status within 50 ms.
// - Device-to-host data packets each come within 500 ms.
// - Status after last device-to-host packet completes within 50 ms.
// - Host-to-device data stage and status within five seconds, host pauses extend it.
// - Class requests obey the standard request limits.
// - Speed is fixed during reset and never changes in operation.
// - Configuration descriptors returned match the current operating speed.
// - Qualifier and other-speed configuration descriptors are served on request.
// - High-speed capable device reports version 0200H.
// - Below version 0200H, other-speed requests are request errors.
// - Request errors stall the next data stage, or the status stage if none.
// - Reset disables remote wakeup.
`timescale 1ns/1ns
`include "udrt_cfg.svh"

module udrt_top #(
  parameter int MS_CYCLES = `UDRT_CLK_KHZ
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Bus state events
  input wire logic bus_reset,
  input wire logic resume_eop,
  input wire logic hs_detect,
  // Setup packet, valid with setup_ack
  input wire logic setup_ack,
  input wire logic [7:0] setup_type,
  input wire logic [7:0] setup_code,
  input wire logic [15:0] setup_value,
  input wire logic [15:0] setup_len,
  // Control transfer stage events
  input wire logic in_pkt_done,
  input wire logic out_pkt_done,
  input wire logic data_end,
  input wire logic status_done,
  // Function side
  input wire logic proc_done,
  input wire logic func_err,
  input wire logic long_op_done,
  input wire logic long_flag_clr,
  // Alternate setting
  input wire logic alt_set,
  input wire logic [2*`UDRT_NUM_EP-1:0] alt_ep_type,
  // Link control outputs
  output logic xfer_ok,
  output logic [`UDRT_ADDRW-1:0] dev_addr,
  output logic proc_start,
  output logic status_ok,
  output logic stall_data,
  output logic stall_status,
  // Device status outputs
  output logic wakeup_en,
  output logic speed_hs,
  output logic desc_hs,
  output logic [15:0] desc_version,
  output logic late,
  output logic long_flag,
  output logic [2*`UDRT_NUM_EP-1:0] ep_type
);

  udrt_tmr_if t ();

  udrt_ms_timer #(
    .CYC_PER_MS(MS_CYCLES)
  ) u_tmr (
    .clock(clock),
    .resetn(resetn),
    .t(t)
  );

  udrt_pkg::udrt_state_t state_r;
  logic [3:0] recov_r;
  logic xfer_ok_r;
  logic speed_hs_r;
  logic desc_hs_r;
  logic [15:0] bcd_r;
  logic [`UDRT_ADDRW-1:0] dev_addr_r;
  logic [`UDRT_ADDRW-1:0] new_addr_r;
  logic addr_pend_r;
  logic wake_pend_r;
  logic wake_val_r;
  logic wakeup_en_r;
  logic proc_start_r;
  logic proc_done_r;
  logic status_ok_r;
  logic stall_data_r;
  logic stall_status_r;
  logic restart_r;
  logic [`UDRT_MSW-1:0] lim_r;
  logic [`UDRT_MSW-1:0] cmd_ms_r;
  logic had_out_r;
  logic late_r;
  logic long_flag_r;
  udrt_pkg::udrt_ep_type_t ep_type_r [`UDRT_NUM_EP];

  // ----------------------------------------
  // Setup decode
  // ----------------------------------------
  logic accept;
  logic [1:0] rtype;
  logic timed;
  logic is_set_addr;
  logic is_wake;
  logic is_other;
  logic req_err;

  assign accept = setup_ack && xfer_ok_r;
  assign rtype = setup_type[`UDRT_TYPE_HI:`UDRT_TYPE_LO];
  assign timed = (rtype == `UDRT_TYPE_STD) || (rtype == `UDRT_TYPE_CLASS);
  assign is_set_addr = (setup_type == 8'h00) && (setup_code == `UDRT_REQ_SET_ADDR);
  assign is_wake = (rtype == `UDRT_TYPE_STD)
    && (setup_type[`UDRT_RECIP_HI:0] == `UDRT_RECIP_DEV)
    && ((setup_code == `UDRT_REQ_SET_FEAT) || (setup_code == `UDRT_REQ_CLR_FEAT))
    && (setup_value == `UDRT_FEAT_WAKEUP);
  assign is_other = (rtype == `UDRT_TYPE_STD) && (setup_code == `UDRT_REQ_GET_DESC)
    && ((setup_value[15:8] == `UDRT_DT_QUAL) || (setup_value[15:8] == `UDRT_DT_OTHER_CFG));
  // Old-version or single-speed devices reject other-speed requests
  assign req_err = (rtype == `UDRT_TYPE_RSVD)
    || (is_other && ((bcd_r < `UDRT_OTHER_SPEED_VER) || !`UDRT_HS_CAPABLE))
    || (is_wake && !`UDRT_WAKE_CAPABLE);

  // ----------------------------------------
  // Reset and resume recovery
  // ----------------------------------------
  // One extra tick: the first tick may land right after the event
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      recov_r <= `UDRT_RECOV_MS + 4'd1;
      xfer_ok_r <= 1'b0;
    end
    else if (bus_reset || resume_eop)
    begin
      recov_r <= `UDRT_RECOV_MS + 4'd1;
      xfer_ok_r <= 1'b0;
    end
    else
    begin
      if (t.tick && recov_r != 4'd0)
        recov_r <= recov_r - 4'd1;
      xfer_ok_r <= (recov_r == 4'd0);
    end
  end

  // ----------------------------------------
  // Speed and descriptor selection
  // ----------------------------------------
  // Speed latched only while the bus is held in reset
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      speed_hs_r <= 1'b0;
    else if (bus_reset)
      speed_hs_r <= hs_detect && `UDRT_HS_CAPABLE;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      desc_hs_r <= 1'b0;
    else if (accept && setup_code == `UDRT_REQ_GET_DESC)
    begin
      if (setup_value[15:8] == `UDRT_DT_OTHER_CFG)
        desc_hs_r <= !speed_hs_r;
      else
        desc_hs_r <= speed_hs_r;
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      bcd_r <= `UDRT_BCD_VER;
    else
      bcd_r <= `UDRT_BCD_VER;
  end

  // ----------------------------------------
  // Control transfer sequencing
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      state_r <= udrt_pkg::s_idle;
    else if (bus_reset)
      state_r <= udrt_pkg::s_idle;
    else if (accept)
    begin
      if (req_err)
        state_r <= udrt_pkg::s_idle;
      else if (setup_len == 16'h0000)
        state_r <= udrt_pkg::s_stat;
      else if (setup_type[`UDRT_DIR_BIT])
        state_r <= udrt_pkg::s_in;
      else
        state_r <= udrt_pkg::s_out;
    end
    else
    begin
      case (state_r)
        udrt_pkg::s_idle:
          state_r <= udrt_pkg::s_idle;
        udrt_pkg::s_in, udrt_pkg::s_out:
          if (status_done)
            state_r <= udrt_pkg::s_idle;
          else if (data_end)
            state_r <= udrt_pkg::s_stat;
        udrt_pkg::s_stat:
          if (status_done)
            state_r <= udrt_pkg::s_idle;
        default:
          state_r <= udrt_pkg::s_idle;
      endcase
    end
  end

  // Set-address waits for its own status stage before acting
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      proc_start_r <= 1'b0;
      proc_done_r <= 1'b0;
    end
    else if (bus_reset)
    begin
      proc_start_r <= 1'b0;
      proc_done_r <= 1'b0;
    end
    else if (accept)
    begin
      proc_start_r <= !req_err && !is_set_addr;
      proc_done_r <= is_set_addr || is_wake;
    end
    else
    begin
      proc_start_r <= 1'b0;
      if (proc_done)
        proc_done_r <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      status_ok_r <= 1'b0;
    else
      status_ok_r <= proc_done_r && !bus_reset && !accept
        && (state_r != udrt_pkg::s_idle) && !stall_data_r && !stall_status_r;
  end

  // ----------------------------------------
  // Request error stalls
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      stall_data_r <= 1'b0;
      stall_status_r <= 1'b0;
    end
    else if (bus_reset)
    begin
      stall_data_r <= 1'b0;
      stall_status_r <= 1'b0;
    end
    else if (accept)
    begin
      stall_data_r <= req_err && (setup_len != 16'h0000);
      stall_status_r <= req_err && (setup_len == 16'h0000);
    end
    else if (func_err && state_r != udrt_pkg::s_idle)
    begin
      // Data stage stall preferred while one is still ahead
      if (state_r == udrt_pkg::s_stat)
        stall_status_r <= 1'b1;
      else
        stall_data_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Address and remote wakeup
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      new_addr_r <= '0;
      addr_pend_r <= 1'b0;
      wake_pend_r <= 1'b0;
      wake_val_r <= 1'b0;
    end
    else if (bus_reset)
    begin
      addr_pend_r <= 1'b0;
      wake_pend_r <= 1'b0;
    end
    else if (accept)
    begin
      new_addr_r <= setup_value[`UDRT_ADDRW-1:0];
      addr_pend_r <= is_set_addr && !req_err;
      wake_pend_r <= is_wake && !req_err;
      wake_val_r <= (setup_code == `UDRT_REQ_SET_FEAT);
    end
    else if (status_done && status_ok_r)
    begin
      addr_pend_r <= 1'b0;
      wake_pend_r <= 1'b0;
    end
  end

  // New address taken at status completion, well inside the grace time
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      dev_addr_r <= '0;
    else if (bus_reset)
      dev_addr_r <= '0;
    else if (status_done && status_ok_r && addr_pend_r)
      dev_addr_r <= new_addr_r;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      wakeup_en_r <= 1'b0;
    else if (bus_reset)
      wakeup_en_r <= 1'b0;
    else if (status_done && status_ok_r && wake_pend_r)
      wakeup_en_r <= wake_val_r;
  end

  // ----------------------------------------
  // Deadline supervision
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      restart_r <= 1'b0;
    else
      restart_r <= accept || in_pkt_done || out_pkt_done || data_end;
  end

  assign t.restart = restart_r;

  // Out packets restart the window, so host pauses never count
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      lim_r <= `UDRT_CMD_MS;
      had_out_r <= 1'b0;
    end
    else if (accept)
    begin
      had_out_r <= !setup_type[`UDRT_DIR_BIT] && (setup_len != 16'h0000);
      if (!timed)
        lim_r <= `UDRT_CMD_MS;
      else if (setup_len == 16'h0000)
        lim_r <= is_set_addr ? `UDRT_NODATA_MS : `UDRT_NODATA_MS;
      else if (setup_type[`UDRT_DIR_BIT])
        lim_r <= `UDRT_IN_PKT_MS;
      else
        lim_r <= `UDRT_CMD_MS;
    end
    else if (state_r == udrt_pkg::s_in && data_end && timed)
      lim_r <= `UDRT_STATUS_MS;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      cmd_ms_r <= '0;
    else if (accept || bus_reset)
      cmd_ms_r <= '0;
    else if (t.tick && cmd_ms_r != {`UDRT_MSW{1'b1}})
      cmd_ms_r <= cmd_ms_r + `UDRT_MSW'(1);
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      late_r <= 1'b0;
    else if (accept || bus_reset)
      late_r <= 1'b0;
    else if (state_r != udrt_pkg::s_idle && !restart_r)
    begin
      if (t.ms > lim_r)
        late_r <= 1'b1;
      if (cmd_ms_r > `UDRT_CMD_MS && !had_out_r)
        late_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Long operation completion flag
  // ----------------------------------------
  // Set beats clear in the same cycle
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      long_flag_r <= 1'b0;
    else if (long_op_done)
      long_flag_r <= 1'b1;
    else if (long_flag_clr)
      long_flag_r <= 1'b0;
  end

  // ----------------------------------------
  // Endpoint transfer types
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `UDRT_NUM_EP; gi++)
    begin : g_ep
      always_ff @(posedge clock or negedge resetn)
      begin
        if (!resetn)
          ep_type_r[gi] <= udrt_pkg::ep_ctrl;
        else if (alt_set)
          ep_type_r[gi] <= udrt_pkg::udrt_ep_type_t'(alt_ep_type[2*gi +: 2]);
      end
      assign ep_type[2*gi +: 2] = ep_type_r[gi];
    end
  endgenerate

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign xfer_ok = xfer_ok_r;
  assign dev_addr = dev_addr_r;
  assign proc_start = proc_start_r;
  assign status_ok = status_ok_r;
  assign stall_data = stall_data_r;
  assign stall_status = stall_status_r;
  assign wakeup_en = wakeup_en_r;
  assign speed_hs = speed_hs_r;
  assign desc_hs = desc_hs_r;
  assign desc_version = bcd_r;
  assign late = late_r;
  assign long_flag = long_flag_r;

endmodule

/* tb/udrt_top_asserts.sv */
`timescale 1ns/1ns
`include "udrt_cfg.svh"

module udrt_top_chk #(
  parameter int MS_CYCLES = `UDRT_CLK_KHZ
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Stimulus
  input wire logic bus_reset,
  input wire logic setup_ack,
  input wire logic [7:0] setup_type,
  input wire logic [15:0] setup_len,
  input wire logic status_done,
  input wire logic long_op_done,
  input wire logic alt_set,
  input wire logic [2*`UDRT_NUM_EP-1:0] alt_ep_type,
  // Results
  input wire logic xfer_ok,
  input wire logic [`UDRT_ADDRW-1:0] dev_addr,
  input wire logic proc_start,
  input wire logic stall_data,
  input wire logic stall_status,
  input wire logic wakeup_en,
  input wire logic speed_hs,
  input wire logic [15:0] desc_version,
  input wire logic late,
  input wire logic long_flag,
  input wire logic [2*`UDRT_NUM_EP-1:0] ep_type
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  property p_ep; alt_set |=> ep_type == $past(alt_ep_type); endproperty
  a_ep: assert property (p_ep) else $error("endpoint types not latched");
  property p_wake; $changed(wakeup_en) |-> $past(status_done) || $past(bus_reset); endproperty
  a_wake: assert property (p_wake) else $error("wakeup changed without request");
  property p_proc; proc_start |-> $past(setup_ack) && $past(xfer_ok); endproperty
  a_proc: assert property (p_proc) else $error("processing without acknowledged setup");
  property p_early; setup_ack && !xfer_ok |=> !proc_start && !late; endproperty
  a_early: assert property (p_early) else $error("setup taken during recovery");
  property p_addr; $changed(dev_addr) |-> $past(status_done) || $past(bus_reset); endproperty
  a_addr: assert property (p_addr) else $error("address switched outside status");
  property p_late; setup_ack && xfer_ok |=> (!late) [*8]; endproperty
  a_late: assert property (p_late) else $error("deadline flagged too early");
  property p_speed; !bus_reset |=> $stable(speed_hs); endproperty
  a_speed: assert property (p_speed) else $error("speed changed in operation");
  property p_ver; desc_version == 16'h0200; endproperty
  a_ver: assert property (p_ver) else $error("wrong descriptor version");
  // Without a data stage the stall has to land on the status stage instead
  property p_rsv;
    setup_ack && xfer_ok && setup_type[6:5] == 2'h3 |=> !proc_start
      && (stall_data == ($past(setup_len) != 16'h0000)) && (stall_status == ($past(setup_len) == 16'h0000));
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved request not stalled");
  property p_long; long_op_done |=> long_flag; endproperty
  a_long: assert property (p_long) else $error("long completion not flagged");
endmodule

bind udrt_top udrt_top_chk #(.MS_CYCLES(MS_CYCLES)) u_udrt_top_chk (
  .clock, .resetn, .bus_reset, .setup_ack, .setup_type, .setup_len, .status_done, .long_op_done, .alt_set,
  .alt_ep_type, .xfer_ok, .dev_addr, .proc_start, .stall_data, .stall_status, .wakeup_en, .speed_hs,
  .desc_version, .late, .long_flag, .ep_type
);

/* tb/udrt_host_model.sv */
`timescale 1ns/1ns

module udrt_host_model
(
  // Clock and readiness
  input wire logic clock,
  input wire logic xfer_ok,
  // Setup packet
  output logic setup_ack,
  output logic [7:0] setup_type,
  output logic [7:0] setup_code,
  output logic [15:0] setup_value,
  output logic [15:0] setup_len,
  // Stage events
  output logic in_pkt_done,
  output logic out_pkt_done,
  output logic data_end,
  output logic status_done
);
  initial
  begin
    {setup_ack, in_pkt_done, out_pkt_done, data_end, status_done} = '0;
    {setup_type, setup_code, setup_value, setup_len} = '0;
  end

  // ------
  // Transactions
  // ------
  // Released fields show inverted data so stale values never look valid
  task automatic send_setup(input logic [7:0] t, input logic [7:0] c, input logic [15:0] v,
                            input logic [15:0] l, input bit early);
    if (!early)
    begin
      wait (xfer_ok === 1'b1);
    end
    @(posedge clock);
    setup_ack <= 1'b1;
    {setup_type, setup_code, setup_value, setup_len} <= {t, c, v, l};
    @(posedge clock);
    setup_ack <= 1'b0;
    {setup_type, setup_code, setup_value, setup_len} <= ~{t, c, v, l};
  endtask

  // Kind 0 in, 1 out, 2 data end, 3 status; gap is a host pause
  task automatic stage(input int k, input int gap);
    repeat (gap) @(posedge clock);
    @(posedge clock);
    {in_pkt_done, out_pkt_done, data_end, status_done} <= 4'h8 >> k;
    @(posedge clock);
    {in_pkt_done, out_pkt_done, data_end, status_done} <= 4'h0;
  endtask
endmodule

/* tb/test_usb_device_request_timing.sv */
`timescale 1ns/1ns
`include "udrt_cfg.svh"

`define CHK(a, e) \
  begin \
    n_tests++; \
    if ((a) !== (e)) \
    begin \
      num_errors++; \
      $display("Error at %0t: got %h expected %h", $time, (a), (e)); \
    end \
  end

module test_usb_device_request_timing;
  localparam int MS = 20;
  localparam int P_DONE = 0, P_ERR = 1, P_LONG = 2, P_CLR = 3, P_RES = 4, P_ALT = 5;
  logic clock, resetn, bus_reset, hs_detect;
  logic [5:0] pls;
  logic [7:0] alt_ep_type, ep_type, exp_ep, setup_type, setup_code;
  logic [15:0] setup_value, setup_len, desc_version;
  logic setup_ack, in_pkt_done, out_pkt_done, data_end, status_done;
  logic xfer_ok, proc_start, status_ok, stall_data, stall_status, wakeup_en, speed_hs, desc_hs, late, long_flag;
  logic [6:0] dev_addr, exp_addr;
  logic [6:0] addr_q[$];
  logic [7:0] dt[3] = '{8'h02, 8'h06, 8'h07};
  int num_errors = 0;
  int n_tests = 0;

  udrt_top #(.MS_CYCLES(MS)) u_udrt_top (
    .clock, .resetn, .bus_reset, .resume_eop(pls[P_RES]), .hs_detect, .setup_ack, .setup_type, .setup_code,
    .setup_value, .setup_len, .in_pkt_done, .out_pkt_done, .data_end, .status_done, .proc_done(pls[P_DONE]),
    .func_err(pls[P_ERR]), .long_op_done(pls[P_LONG]), .long_flag_clr(pls[P_CLR]), .alt_set(pls[P_ALT]),
    .alt_ep_type, .xfer_ok, .dev_addr, .proc_start, .status_ok, .stall_data, .stall_status, .wakeup_en,
    .speed_hs, .desc_hs, .desc_version, .late, .long_flag, .ep_type
  );
  udrt_host_model u_udrt_host_model (
    .clock, .xfer_ok, .setup_ack, .setup_type, .setup_code, .setup_value, .setup_len, .in_pkt_done,
    .out_pkt_done, .data_end, .status_done
  );

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ------
  // Helpers
  // ------
  task automatic pulse(input int k);
    @(posedge clock);
    pls <= 6'h01 << k;
    @(posedge clock);
    pls <= 6'h00;
  endtask

  task automatic wait_hi(ref logic s, input int lim);
    for (int i = 0; i < lim && s !== 1'b1; i++) @(negedge clock);
  endtask

  task automatic recover(input string s);
    time t0;
    t0 = $time;
    wait_hi(xfer_ok, 15 * MS);
    `CHK(($time - t0) <= 12 * MS * 8, 1'b1)
    $display("Test %s finished", s);
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial
  begin
    repeat (400 * MS) @(posedge clock);
    num_errors++;
    end_sim();
  end

  // ------
  // Tests
  // ------
  initial
  begin
    resetn = 1'b0;
    {bus_reset, hs_detect, pls, alt_ep_type} = '0;
    void'($urandom(81));
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    @(negedge clock);
    `CHK({xfer_ok, wakeup_en, dev_addr}, 9'h000)
    `CHK(desc_version, 16'h0200)
    u_udrt_host_model.send_setup(8'h00, 8'h05, 16'h0011, 16'h0000, 1'b1);
    @(negedge clock);
    `CHK({proc_start, xfer_ok}, 2'b00)
    recover("power reset");
    repeat (3)
    begin
      addr_q.push_back(7'($urandom_range(1, 127)));
      u_udrt_host_model.send_setup(8'h00, 8'h05, {9'h000, addr_q[$]}, 16'h0000, 1'b0);
      @(negedge clock);
      `CHK(proc_start, 1'b0)
      wait_hi(status_ok, 50 * MS);
      `CHK({status_ok, late}, 2'b10)
      u_udrt_host_model.stage(3, 0);
      @(negedge clock);
      exp_addr = addr_q.pop_front();
      `CHK(dev_addr, exp_addr)
    end
    $display("Test set address finished");
    for (int i = 0; i < 3; i++)
    begin
      u_udrt_host_model.send_setup(8'h00, (i == 1) ? 8'h01 : 8'h03, 16'h0001, 16'h0000, 1'b0);
      wait_hi(status_ok, 50 * MS);
      u_udrt_host_model.stage(3, 0);
      @(negedge clock);
      `CHK(wakeup_en, 1'(i != 1))
    end
    @(posedge clock);
    bus_reset <= 1'b1;
    hs_detect <= 1'b1;
    repeat (4) @(posedge clock);
    bus_reset <= 1'b0;
    hs_detect <= 1'b0;
    @(negedge clock);
    `CHK({wakeup_en, dev_addr}, 8'h00)
    `CHK({speed_hs, desc_hs}, 2'b10)
    recover("bus reset");
    `CHK(speed_hs, 1'b1)
    for (int i = 0; i < 3; i++)
    begin
      u_udrt_host_model.send_setup(8'h80, 8'h06, {dt[i], 8'h00}, 16'h0012, 1'b0);
      @(negedge clock);
      `CHK({proc_start, stall_data, desc_hs}, {2'b10, 1'(i != 2)})
      pulse(P_DONE);
      u_udrt_host_model.stage(0, 2 * MS);
      u_udrt_host_model.stage(2, 0);
      wait_hi(status_ok, 50 * MS);
      `CHK({status_ok, late}, 2'b10)
      u_udrt_host_model.stage(3, 0);
    end
    u_udrt_host_model.send_setup(8'h21, 8'h09, 16'h0000, 16'h0010, 1'b0);
    @(negedge clock);
    `CHK(proc_start, 1'b1)
    u_udrt_host_model.stage(1, 60 * MS);
    u_udrt_host_model.stage(2, 0);
    @(negedge clock);
    `CHK(status_ok, 1'b0)
    pulse(P_DONE);
    wait_hi(status_ok, 4);
    `CHK({status_ok, late}, 2'b10)
    u_udrt_host_model.stage(3, 0);
    $display("Test data stages finished");
    u_udrt_host_model.send_setup(8'h60, 8'h00, 16'h0000, 16'h0000, 1'b0);
    @(negedge clock);
    `CHK({proc_start, stall_data, stall_status}, 3'b001)
    u_udrt_host_model.send_setup(8'h00, 8'h09, 16'h0001, 16'h0000, 1'b0);
    pulse(P_ERR);
    @(negedge clock);
    `CHK({stall_data, stall_status}, 2'b01)
    u_udrt_host_model.send_setup(8'h00, 8'h09, 16'h0001, 16'h0000, 1'b0);
    repeat (45 * MS) @(negedge clock);
    `CHK({late, stall_status}, 2'b00)
    repeat (8 * MS) @(negedge clock);
    `CHK(late, 1'b1)
    $display("Test errors and deadlines finished");
    exp_ep = 8'($urandom);
    @(posedge clock);
    alt_ep_type <= exp_ep;
    pulse(P_ALT);
    alt_ep_type <= ~exp_ep;
    @(negedge clock);
    `CHK(ep_type, exp_ep)
    pulse(P_LONG);
    @(negedge clock);
    `CHK(long_flag, 1'b1)
    pulse(P_CLR);
    repeat (2) @(negedge clock);
    `CHK(long_flag, 1'b0)
    pulse(P_RES);
    @(negedge clock);
    `CHK(xfer_ok, 1'b0)
    recover("resume");
    end_sim();
  end
endmodule
